// File: rtl/emss_cfg.svh
// Constants for the exception mask and stack select block
// Notes on behaviour
// - Execution state bit loads from target bit zero
// - Executing with state bit clear raises fault
// - Special-register moves access masks; state instruction sets
// - Configurable-priority mask blocks configurable-priority exceptions
// - Escalation mask blocks all but non-maskable
// - Non-NMI handler exit clears escalation mask
// - Nonzero threshold blocks equal or lower priority
// - Only threshold bits seven down to M exist
// - Control register picks stack and privilege
// - Reset uses main stack; Thread-mode write selects process
// - Matching exception return selects process stack
// - All exceptions but reset run in Handler
// - Data endianness fixed; fetch and private bus little
// - Word, halfword and byte data sizes supported
// - Control bit one selects stack, zero main
`ifndef EMSS_CFG_SVH
`define EMSS_CFG_SVH
// Special-register selectors on the move port
`define EMSS_SEL_CFGMASK   3'h0
`define EMSS_SEL_ESCMASK   3'h1
`define EMSS_SEL_THRESH    3'h2
`define EMSS_SEL_CONTROL   3'h3
`define EMSS_SEL_STATUS    3'h4
// Field positions
`define EMSS_MASK_BIT      0
`define EMSS_CTRL_PRIV_BIT 0
`define EMSS_CTRL_STK_BIT  1
`define EMSS_CTRL_FP_BIT   2
`define EMSS_THRESH_MSB    7
`define EMSS_THRESH_M      4
`define EMSS_EXEC_BIT      24
`define EMSS_NMI_NUM       9'h002
`define EMSS_EXCRET_STK_BIT 2
`define EMSS_EXCRET_THR_BIT 3
// Reset values
`define EMSS_RST_WORD      32'h0000_0000
`define EMSS_RST_EXEC      1'h1
// Implementation choices
`define EMSS_BIG_ENDIAN    1'h0
`endif

// File: rtl/emss_pkg.sv
// Types for the exception mask and stack select block
package emss_pkg;
  typedef enum logic [1:0] {
    EMSS_THREAD  = 2'b00,
    EMSS_HANDLER = 2'b01,
    EMSS_LOCKUP  = 2'b10
  } emss_mode_t;
  // Special-register move request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  sel;
    logic [31:0] data;
  } emss_move_t;
  // Processor-state instruction
  typedef struct packed {
    logic en;
    logic disable_irq;
    logic tgt_escmask;
  } emss_cps_t;
  // Pending exception offered by the interrupt controller
  typedef struct packed {
    logic       valid;
    logic [8:0] num;
    logic [7:0] prio;
    logic       configurable;
  } emss_pend_t;
endpackage : emss_pkg

// File: rtl/emss_core.sv
// Exception mask registers, stack select and execution state bit
`timescale 1ns/1ns
`default_nettype none
`include "emss_cfg.svh"
module emss_core (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // Special-register moves and state instruction
  input  wire emss_pkg::emss_move_t move_in,
  input  wire emss_pkg::emss_cps_t  cps_in,
  // State-bit sources: branch exchange, load or pop to pc
  input  wire logic               branch_load_in,
  input  wire logic [31:0]        branch_target_in,
  // Exception entry and return
  input  wire logic               exc_entry_in,
  input  wire logic [31:0]        exc_vector_in,
  input  wire logic [8:0]         exc_entry_num_in,
  input  wire logic               exception_return_code_in,
  input  wire logic [31:0]        exception_return_code_code_in,
  input  wire logic [31:0]        stacked_status_in,
  input  wire logic [8:0]         exc_active_num_in,
  // Instruction issue and pending exception
  input  wire logic               instr_issue_in,
  input  wire emss_pkg::emss_pend_t pend_in,
  // Outputs
  output logic [31:0]             move_rdata_out,
  output logic                    take_exc_out,
  output logic                    process_stack_out,
  output logic                    unpriv_out,
  output logic                    handler_mode_out,
  output logic                    exec_state_out,
  output logic                    state_fault_out,
  output logic                    big_endian_data_out,
  output logic                    little_fetch_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic                 cfgmask_q, cfgmask_d;
  logic                 escmask_q, escmask_d;
  logic [7:0]           thresh_q,  thresh_d;
  logic                 stk_q, stk_d, priv_q, priv_d;
  logic                 exec_q, exec_d;
  emss_pkg::emss_mode_t mode_q, mode_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 take_q, take_d;
  logic                 fault_q, fault_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of move port
  wire wr_pri  = move_in.wr && (move_in.sel == `EMSS_SEL_CFGMASK);
  wire wr_esc  = move_in.wr && (move_in.sel == `EMSS_SEL_ESCMASK);
  wire wr_thr  = move_in.wr && (move_in.sel == `EMSS_SEL_THRESH);
  wire wr_ctl  = move_in.wr && (move_in.sel == `EMSS_SEL_CONTROL);
  wire cps_pri = cps_in.en && !cps_in.tgt_escmask;
  wire cps_esc = cps_in.en && cps_in.tgt_escmask;
  // Low threshold bits are not stored, so they read zero
  wire [7:0] thr_wmask = 8'hff << `EMSS_THRESH_M;
  wire       in_thread = (mode_q == emss_pkg::EMSS_THREAD);
  // Handler exit other than the non-maskable one drops the escalation mask
  wire esc_clr = exception_return_code_in && (exc_active_num_in != `EMSS_NMI_NUM);
  wire ret_to_thread = exception_return_code_in && exception_return_code_code_in[`EMSS_EXCRET_THR_BIT];
  // Read mux: reserved bits stay zero
  wire [31:0] rd_pri = {31'h0, cfgmask_q};
  wire [31:0] rd_esc = {31'h0, escmask_q};
  wire [31:0] rd_thr = {24'h0, thresh_q};
  wire [31:0] rd_ctl = {29'h0, 1'b0, stk_q, priv_q};
  wire [31:0] rd_sts = {7'h0, exec_q, 24'h0};
  wire [31:0] rd_sel = (move_in.sel == `EMSS_SEL_CFGMASK) ? rd_pri :
                       (move_in.sel == `EMSS_SEL_ESCMASK) ? rd_esc :
                       (move_in.sel == `EMSS_SEL_THRESH)  ? rd_thr :
                       (move_in.sel == `EMSS_SEL_CONTROL) ? rd_ctl :
                       (move_in.sel == `EMSS_SEL_STATUS)  ? rd_sts : `EMSS_RST_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Activation gating
  wire is_nmi   = (pend_in.num == `EMSS_NMI_NUM);
  wire blk_pri  = cfgmask_q && pend_in.configurable;
  wire blk_esc  = escmask_q && !is_nmi;
  wire blk_thr  = (thresh_q != 8'h00) && pend_in.configurable &&
                  (pend_in.prio >= thresh_q);
  wire can_take = pend_in.valid && !blk_pri && !blk_esc && !blk_thr &&
                  (mode_q != emss_pkg::EMSS_LOCKUP);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic; hardware events win over software writes
  always_comb begin
    cfgmask_d = cfgmask_q;
    escmask_d = escmask_q;
    thresh_d  = thresh_q;
    stk_d     = stk_q;
    priv_d    = priv_q;
    exec_d    = exec_q;
    mode_d    = mode_q;
    fault_d   = 1'b0;
    rdata_d   = move_in.rd ? rd_sel : rdata_q;
    take_d    = can_take;
    if (wr_pri) begin
      cfgmask_d = move_in.data[`EMSS_MASK_BIT];
    end
    if (cps_pri) begin
      cfgmask_d = cps_in.disable_irq;
    end
    if (wr_esc) begin
      escmask_d = move_in.data[`EMSS_MASK_BIT];
    end
    if (cps_esc) begin
      escmask_d = cps_in.disable_irq;
    end
    if (esc_clr) begin
      escmask_d = 1'b0;
    end
    if (wr_thr) begin
      thresh_d = move_in.data[7:0] & thr_wmask;
    end
    if (wr_ctl) begin
      priv_d = move_in.data[`EMSS_CTRL_PRIV_BIT];
      // The stack select is written in Thread mode only; a write in Handler mode leaves it as it is
      if (in_thread) begin
        stk_d = move_in.data[`EMSS_CTRL_STK_BIT];
      end
    end
    if (branch_load_in) begin
      exec_d = branch_target_in[0];
    end
    case (mode_q)
      emss_pkg::EMSS_THREAD: begin
        if (instr_issue_in && !exec_q) begin
          mode_d  = emss_pkg::EMSS_HANDLER;
          fault_d = 1'b1;
        end
      end
      emss_pkg::EMSS_HANDLER: begin
        if (instr_issue_in && !exec_q) begin
          mode_d  = emss_pkg::EMSS_LOCKUP;
          fault_d = 1'b1;
        end
        if (ret_to_thread) begin
          mode_d = emss_pkg::EMSS_THREAD;
          stk_d  = exception_return_code_code_in[`EMSS_EXCRET_STK_BIT];
        end
      end
      emss_pkg::EMSS_LOCKUP: begin
        mode_d = emss_pkg::EMSS_LOCKUP;
      end
      default: begin
        mode_d = emss_pkg::EMSS_THREAD;
      end
    endcase
    if (exception_return_code_in) begin
      exec_d = stacked_status_in[`EMSS_EXEC_BIT];
    end
    // Reset entry also loads the state bit from its vector but leaves the mode unchanged
    if (exc_entry_in) begin
      exec_d = exc_vector_in[0];
      if (exc_entry_num_in != 9'h000) begin
        mode_d = emss_pkg::EMSS_HANDLER;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cfgmask_q <= 1'b0;
      escmask_q <= 1'b0;
      thresh_q  <= 8'h00;
      stk_q     <= 1'b0;
      priv_q    <= 1'b0;
      exec_q    <= `EMSS_RST_EXEC;
      mode_q    <= emss_pkg::EMSS_THREAD;
      rdata_q   <= `EMSS_RST_WORD;
      take_q    <= 1'b0;
      fault_q   <= 1'b0;
    end else begin
      cfgmask_q <= cfgmask_d;
      escmask_q <= escmask_d;
      thresh_q  <= thresh_d;
      stk_q     <= stk_d;
      priv_q    <= priv_d;
      exec_q    <= exec_d;
      mode_q    <= mode_d;
      rdata_q   <= rdata_d;
      take_q    <= take_d;
      fault_q   <= fault_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Endianness and handler indicators; fetches and private bus stay little
  logic hmode_q, bige_q, lfetch_q;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      hmode_q  <= 1'b0;
      bige_q   <= 1'b0;
      lfetch_q <= 1'b1;
    end else begin
      hmode_q  <= (mode_d != emss_pkg::EMSS_THREAD);
      bige_q   <= `EMSS_BIG_ENDIAN;
      lfetch_q <= 1'b1;
    end
  end

  // Data sizes are handled by the load-store path; this block only passes words
  assign move_rdata_out      = rdata_q;
  assign take_exc_out        = take_q;
  // The stack output follows the select as held, in Handler mode as well
  assign process_stack_out   = stk_q;
  assign unpriv_out          = priv_q;
  assign handler_mode_out    = hmode_q;
  assign exec_state_out      = exec_q;
  assign state_fault_out     = fault_q;
  assign big_endian_data_out = bige_q;
  assign little_fetch_out    = lfetch_q;
endmodule : emss_core
`default_nettype wire

// File: testbench/emss_core_props.sv
// Assertion checker bound to the exception mask and stack select core
`timescale 1ns/1ns
`default_nettype none
module emss_core_props (
  // Clock, reset and requests
  input wire logic                 clk_in,
  input wire logic                 rst_b_in,
  input wire emss_pkg::emss_move_t move_in,
  input wire emss_pkg::emss_cps_t  cps_in,
  input wire logic                 branch_load_in,
  input wire logic [31:0]          branch_target_in,
  input wire logic                 exc_entry_in,
  input wire logic [31:0]          exc_vector_in,
  input wire logic [8:0]           exc_entry_num_in,
  input wire logic                 exception_return_code_in,
  input wire logic [31:0]          exception_return_code_code_in,
  input wire logic                 instr_issue_in,
  input wire emss_pkg::emss_pend_t pend_in,
  // Observed outputs
  input wire logic [31:0]          move_rdata_out,
  input wire logic                 take_exc_out,
  input wire logic                 process_stack_out,
  input wire logic                 handler_mode_out,
  input wire logic                 exec_state_out,
  input wire logic                 state_fault_out,
  input wire logic                 big_endian_data_out,
  input wire logic                 little_fetch_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Nothing that could change a mask lands in this cycle
  wire quiet = !(cps_in.en || move_in.wr || exception_return_code_in);
  ////////////////////////////////////////////////////////////////////////////////
  a_branch_state: assert property (branch_load_in && !exc_entry_in && !exception_return_code_in |=>
    exec_state_out == $past(branch_target_in[0])) else $error("state bit not from target");
  a_entry_state: assert property (exc_entry_in |=>
    exec_state_out == $past(exc_vector_in[0])) else $error("state bit not from vector");
  a_fault_clear: assert property (instr_issue_in && !exec_state_out && !handler_mode_out
    |=> state_fault_out) else $error("no fault with state bit clear");
  a_cfg_blocks: assert property (cps_in.en && cps_in.disable_irq && !cps_in.tgt_escmask
    ##1 quiet ##1 pend_in.valid && pend_in.configurable && quiet |=> !take_exc_out)
    else $error("configurable exception taken while masked");
  a_esc_blocks: assert property (move_in.wr && move_in.sel == 3'h1 && move_in.data[0]
    && !cps_in.en ##1 quiet ##1 pend_in.valid && pend_in.num != 9'h002 && quiet
    |=> !take_exc_out) else $error("exception taken while escalation masked");
  a_reset_values: assert property (disable iff (1'b0) !rst_b_in |=>
    !process_stack_out && exec_state_out && !handler_mode_out) else $error("bad reset state");
  a_fixed_endian: assert property (little_fetch_out && !big_endian_data_out)
    else $error("endianness not fixed");
  a_stack_write: assert property (move_in.wr && move_in.sel == 3'h3 && !handler_mode_out
    && !exc_entry_in && !exception_return_code_in |=> process_stack_out == $past(move_in.data[1]))
    else $error("stack select write lost");
  a_return_process: assert property (exception_return_code_in && !exc_entry_in && handler_mode_out
    && exception_return_code_code_in[3:2] == 2'h3 |=> process_stack_out && !handler_mode_out)
    else $error("return did not select process stack");
  a_entry_handler: assert property (exc_entry_in && exc_entry_num_in != 9'h000
    |=> handler_mode_out) else $error("entry not in handler mode");
  a_mask_reads: assert property (move_in.rd && move_in.sel < 3'h2
    |=> move_rdata_out[31:1] == 31'h0) else $error("reserved mask bits not zero");
endmodule : emss_core_props
bind emss_core emss_core_props u_emss_core_props (.*);
`default_nettype wire

// File: testbench/exception_mask_and_stack_select_test.sv
// Self-checking bench for the exception mask and stack select core
`timescale 1ns/1ns
`default_nettype none
module exception_mask_and_stack_select_test;
  logic                 clk_in, rst_b_in, br, ent, ret, iss, rd_was, pd_was;
  logic [31:0]          tgt, vec, code, rdata, got, rv;
  logic [8:0]           ent_num;
  logic                 take, chk_st, st_was;
  logic                 ps, up, hm, ex, ft, be, lf;
  emss_pkg::emss_move_t mv;
  emss_pkg::emss_cps_t  change_processor_state;
  emss_pkg::emss_pend_t pd;
  logic [31:0]          exp_q[$];
  int                   bad_count, cmp_count;
  emss_core u_emss_core (.clk_in(clk_in), .rst_b_in(rst_b_in), .move_in(mv), .cps_in(change_processor_state),
    .branch_load_in(br), .branch_target_in(tgt), .exc_entry_in(ent), .exc_vector_in(vec),
    .exc_entry_num_in(ent_num), .exception_return_code_in(ret), .exception_return_code_code_in(code),
    .stacked_status_in(32'h0100_0000), .exc_active_num_in(ent_num), .instr_issue_in(iss),
    .pend_in(pd), .move_rdata_out(rdata), .take_exc_out(take), .process_stack_out(ps),
    .unpriv_out(up), .handler_mode_out(hm), .exec_state_out(ex), .state_fault_out(ft),
    .big_endian_data_out(be), .little_fetch_out(lf));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic idle();
    mv = '0;
    change_processor_state = '0;
    pd = '0;
    {br, ent, ret, iss, chk_st} = '0;
  endtask : idle
  // Hold one edge, then an idle edge so no strobe is set twice in a time step
  task automatic fin();
    @(posedge clk_in);
    #1;
    idle();
    @(posedge clk_in);
    #1;
  endtask : fin
  task automatic mov(input logic w, input logic [2:0] s, input logic [31:0] d, e);
    if (!w) exp_q.push_back(e);
    mv = '{wr: w, rd: !w, sel: s, data: d};
    fin();
  endtask : mov
  task automatic pend(input logic [8:0] n, input logic [7:0] p, input logic c, e);
    exp_q.push_back({31'h0, e});
    pd = '{valid: 1'b1, num: n, prio: p, configurable: c};
    fin();
  endtask : pend
  // Status outputs packed as {stack, unpriv, handler, state, fault, big, little}
  task automatic st(input logic [31:0] e);
    exp_q.push_back(e);
    chk_st = 1'b1;
    fin();
  endtask : st
  task automatic cps_op(input logic v, t);
    change_processor_state = '{en: 1'b1, disable_irq: v, tgt_escmask: t};
    fin();
  endtask : cps_op
  task automatic exc(input logic e, input logic [8:0] n, input logic [31:0] c);
    ent_num = n;
    code = c;
    vec = 32'h1;
    ent = e;
    ret = !e;
    fin();
  endtask : exc
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // Monitor: a read or pend one cycle back owns the oldest note
  initial forever begin
    @(posedge clk_in);
    #3;
    if (rd_was || pd_was || st_was) begin
      got = rd_was ? rdata : pd_was ? {31'h0, take} :
            {25'h0, ps, up, hm, ex, ft, be, lf};
      rv = exp_q.pop_front();
      cmp_count++;
      if (got !== rv) begin
        bad_count++;
        $display("[FAIL] %0t got %h exp %h", $time, got, rv);
      end
    end
    rd_was = mv.rd;
    pd_was = pd.valid;
    st_was = chk_st;
  end
  initial begin
    #40000;
    bad_count++;
    end_sim();
  end
  initial begin
    {rd_was, pd_was, st_was, rst_b_in} = '0;
    {tgt, vec, code, ent_num} = '0;
    idle();
    void'($urandom(85916));
    repeat (20) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (int s = 0; s < 4; s++) mov(0, s[2:0], 0, 0);
    st(32'h09);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      rv = $urandom();
      for (int s = 0; s < 3; s++) begin
        mov(1, s[2:0], rv, 0);
        mov(0, s[2:0], 0, (s == 2) ? {24'h0, rv[7:4], 4'h0} : {31'h0, rv[0]});
      end
    end
    for (int s = 0; s < 3; s++) mov(1, s[2:0], 0, 0);
    $display("Test register access done");
    cps_op(1, 0);
    pend(9'h010, 8'h40, 1, 0);
    pend(9'h003, 8'h00, 0, 1);
    cps_op(0, 0);
    pend(9'h010, 8'h40, 1, 1);
    mov(1, 3'h1, 1, 0);
    pend(9'h003, 8'h00, 0, 0);
    pend(9'h002, 8'h00, 0, 1);
    exc(1, 9'h002, 0);
    exc(0, 9'h002, 0);
    mov(0, 3'h1, 0, 1);
    exc(0, 9'h005, 32'h8);
    mov(0, 3'h1, 0, 0);
    $display("Test masks done");
    mov(1, 3'h2, 32'h80, 0);
    pend(9'h010, 8'h80, 1, 0);
    pend(9'h010, 8'h7f, 1, 1);
    mov(1, 3'h2, 0, 0);
    pend(9'h010, 8'hff, 1, 1);
    $display("Test threshold done");
    mov(1, 3'h3, 3, 0);
    mov(0, 3'h3, 0, 3);
    st(32'h69);
    mov(1, 3'h3, 0, 0);
    exc(1, 9'h00b, 0);
    st(32'h19);
    exc(0, 9'h00b, 32'hc);
    mov(0, 3'h3, 0, 2);
    br = 1'b1;
    st(32'h41);
    iss = 1'b1;
    st(32'h55);
    $display("Test stack and state done");
    fin();
    end_sim();
  end
endmodule : exception_mask_and_stack_select_test
`default_nettype wire
